// >>> monitor_pkg.sv
package monitor_pkg;

	typedef logic [7:0] byte_t;

	// Read handshake phases of the register slave.
	typedef enum logic [1:0]
	{
		RD_IDLE,
		RD_FETCH,
		RD_DONE
	} rd_phase_t;

	// Register indices; the byte address on the bus is four times the index.
	localparam byte_t IDX_MEAS       = 8'h20;
	localparam byte_t IDX_TACH0      = 8'h28;
	localparam byte_t IDX_DUTY0      = 8'h30;
	localparam byte_t IDX_CTRL       = 8'h40;
	localparam byte_t IDX_STATUS     = 8'h41;
	localparam byte_t IDX_LIM_LO     = 8'h44;
	localparam byte_t IDX_LIM_HI     = 8'h45;
	localparam byte_t IDX_MANUAL     = 8'h46;
	localparam byte_t IDX_PARAM0     = 8'h50;
	localparam byte_t IDX_IRQ_EN     = 8'h7C;
	localparam int    NUM_TACH_REGS  = 8;
	localparam int    NUM_FANS       = 3;
	localparam int    NUM_PARAMS     = 16;

	// Control and interrupt enable register field positions.
	localparam int    BIT_START      = 0;
	localparam int    BIT_LOCK       = 1;
	localparam int    BIT_READY      = 2;
	localparam int    BIT_OVERRIDE   = 3;
	localparam int    BIT_IRQ_EN     = 0;

	// Values after reset and built-in defaults.
	localparam byte_t CTRL_RST       = 8'h00;
	localparam byte_t LIM_LO_RST     = 8'h00;
	localparam byte_t LIM_HI_RST     = 8'hFF;
	localparam byte_t DEF_LIM_LO     = 8'h00;
	localparam byte_t DEF_LIM_HI     = 8'hFF;
	localparam byte_t DUTY_FULL      = 8'hFF;
	localparam byte_t STATUS_RST     = 8'h00;

	// Timing.
	localparam int    CLK_HZ         = 10_000_000;
	localparam int    STARTUP_MS     = 82;
	localparam int    STARTUP_CYC    = STARTUP_MS * (CLK_HZ / 1000);
	localparam int    SETTLE_W       = 20;
	localparam int    PWM_DIV_CYC    = 4;
	localparam int    PWM_DIV_W      = 2;

endpackage : monitor_pkg

// >>> param_ram.sv
`timescale 1ns/100ps
module param_ram
	import monitor_pkg::*;
(
	input  wire logic                clk_sys,
	input  wire logic                sys_rst,
	input  wire logic                we,
	input  wire logic [3:0]          waddr,
	input  wire monitor_pkg::byte_t  wdata,
	input  wire logic [3:0]          raddr,
	output monitor_pkg::byte_t       rdata_q
);

	byte_t mem [NUM_PARAMS];

	// Storage holds its contents across run and stop; only the write enable changes it.
	always_ff @(posedge clk_sys)
	begin
		if (we)
		begin
			mem[waddr] <= wdata;
		end
	end

	// Registered read port, loaded every cycle from the held read address.
	always_ff @(posedge clk_sys or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			rdata_q <= 8'h00;
		end
		else
		begin
			rdata_q <= mem[raddr];
		end
	end

endmodule : param_ram

// >>> pwm_chan.sv
`timescale 1ns/100ps
module pwm_chan
	import monitor_pkg::*;
(
	input  wire logic                clk_sys,
	input  wire logic                sys_rst,
	input  wire logic                tick,
	input  wire monitor_pkg::byte_t  duty,
	output logic                     pin_out,
	output logic                     pin_oe_q
);

	byte_t cnt_q;

	// Period counter advancing on each PWM clock enable; 256 PWM clocks per period.
	always_ff @(posedge clk_sys or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			cnt_q <= 8'h00;
		end
		else if (tick)
		begin
			cnt_q <= cnt_q + 8'h01;
		end
	end

	// Open drain: released while the count is below duty, driven low otherwise.
	always_ff @(posedge clk_sys or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			pin_oe_q <= 1'b0;
		end
		else
		begin
			pin_oe_q <= (cnt_q >= duty);
		end
	end

	// The pin is only ever pulled low.
	assign pin_out = 1'b0;

endmodule : pwm_chan

// >>> monitor_run_lock_control.sv
// The Avalon-MM slave port is this design's own decision.
`timescale 1ns/100ps
module monitor_run_lock_control
	import monitor_pkg::*;
#(
	parameter int STARTUP_CYCLES = STARTUP_CYC
)
(
	input  wire logic                clk_sys,
	input  wire logic                sys_rst,
	input  wire logic [9:0]          avs_address,
	input  wire logic                avs_read,
	input  wire logic                avs_write,
	input  wire logic [31:0]         avs_writedata,
	input  wire logic [3:0]          avs_byteenable,
	output logic [31:0]              avs_readdata,
	output logic                     avs_waitrequest,
	input  wire logic                meas_strobe,
	input  wire monitor_pkg::byte_t  meas_sample,
	input  wire logic [6:0]          limit_event,
	input  wire logic [3:0][15:0]    tach_count,
	input  wire logic [2:0][7:0]     auto_duty,
	output logic [2:0]               pwm_out,
	output logic [2:0]               pwm_oe,
	output logic                     monitor_run,
	output logic                     meas_valid,
	output logic                     irq_pin_enable
);

	// Index comparisons used by both the write decode and the read mux.
	function automatic logic in_range(input byte_t a, input byte_t base, input int n);
		return (a >= base) && ({24'h000000, a} < ({24'h000000, base} + 32'(n)));
	endfunction : in_range

	byte_t         idx;
	byte_t         wbyte;
	logic          wr_lo;
	logic          param_wr_ok;
	logic          start_q;
	logic          lock_q;
	logic          override_q;
	logic          ready_q;
	logic          irq_en_q;
	byte_t         lim_lo_q;
	byte_t         lim_hi_q;
	logic [2:0]    manual_q;
	byte_t         duty_q [NUM_FANS];
	byte_t         eff_duty [NUM_FANS];
	byte_t         rd_duty [NUM_FANS];
	byte_t         eff_lo;
	byte_t         eff_hi;
	byte_t         meas_q;
	byte_t         status_q;
	byte_t         set_vec;
	logic [SETTLE_W-1:0] settle_q;
	logic          settled;
	logic          violation;
	rd_phase_t     rd_q;
	logic          rd_done;
	byte_t         rd_mux;
	byte_t         param_rdata;
	logic          param_we;
	logic [PWM_DIV_W-1:0] div_q;
	logic          pwm_tick;

	// Only byte lane 0 carries data; the upper lanes read as zero.
	assign idx   = avs_address[9:2];
	assign wbyte = avs_writedata[7:0];
	assign wr_lo = avs_write && avs_byteenable[0];

	// Limits and parameters accept writes only while stopped and unlocked.
	assign param_wr_ok = !start_q && !lock_q;

	// Control register; once locked, run and lock ignore writes, override never does.
	always_ff @(posedge clk_sys or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			start_q    <= CTRL_RST[BIT_START];
			lock_q     <= CTRL_RST[BIT_LOCK];
			override_q <= CTRL_RST[BIT_OVERRIDE];
		end
		else if (wr_lo && (idx == IDX_CTRL))
		begin
			if (!lock_q)
			begin
				start_q <= wbyte[BIT_START];
				lock_q  <= wbyte[BIT_LOCK];
			end
			override_q <= wbyte[BIT_OVERRIDE];
		end
	end

	// Ready is caught one edge after reset release and then stays set.
	always_ff @(posedge clk_sys or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			ready_q <= 1'b0;
		end
		else
		begin
			ready_q <= 1'b1;
		end
	end

	// The interrupt pin enable is writable in every state.
	always_ff @(posedge clk_sys or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			irq_en_q <= 1'b0;
		end
		else if (wr_lo && (idx == IDX_IRQ_EN))
		begin
			irq_en_q <= wbyte[BIT_IRQ_EN];
		end
	end

	// Limit and fan mode registers; the run bit never touches their contents.
	always_ff @(posedge clk_sys or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			lim_lo_q <= LIM_LO_RST;
			lim_hi_q <= LIM_HI_RST;
			manual_q <= 3'h0;
		end
		else if (wr_lo && param_wr_ok)
		begin
			if (idx == IDX_LIM_LO)
			begin
				lim_lo_q <= wbyte;
			end
			if (idx == IDX_LIM_HI)
			begin
				lim_hi_q <= wbyte;
			end
			if (idx == IDX_MANUAL)
			begin
				manual_q <= wbyte[2:0];
			end
		end
	end

	// Remaining parameters live in a small memory with the same write protection.
	assign param_we = wr_lo && param_wr_ok && in_range(idx, IDX_PARAM0, NUM_PARAMS);

	param_ram u_param_ram
	(
		.clk_sys (clk_sys),
		.sys_rst (sys_rst),
		.we      (param_we),
		.waddr   (idx[3:0]),
		.wdata   (wbyte),
		.raddr   (idx[3:0]),
		.rdata_q (param_rdata)
	);

	// Duty registers stay writable while running in manual mode if unlocked; a stopped
	// auto-mode write lands in the hidden copy, shown only once that fan is set to manual.
	always_ff @(posedge clk_sys or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			for (int n = 0; n < NUM_FANS; n++)
			begin
				duty_q[n] <= DUTY_FULL;
			end
		end
		else if (wr_lo && !lock_q)
		begin
			for (int n = 0; n < NUM_FANS; n++)
			begin
				if ((idx == (IDX_DUTY0 + 8'(n))) && (manual_q[n] || !start_q))
				begin
					duty_q[n] <= wbyte;
				end
			end
		end
	end

	// Duty actually driven, and the value shown when a duty register is read.
	always_comb
	begin
		for (int n = 0; n < NUM_FANS; n++)
		begin
			if (override_q || !start_q)
			begin
				eff_duty[n] = DUTY_FULL;
			end
			else
			begin
				eff_duty[n] = manual_q[n] ? duty_q[n] : auto_duty[n];
			end
			rd_duty[n] = manual_q[n] ? duty_q[n] : eff_duty[n];
		end
	end

	// PWM clock enable from a divider of the system clock.
	always_ff @(posedge clk_sys or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			div_q <= '0;
		end
		else if (pwm_tick)
		begin
			div_q <= '0;
		end
		else
		begin
			div_q <= div_q + 1'b1;
		end
	end

	assign pwm_tick = (div_q == PWM_DIV_W'(PWM_DIV_CYC - 1));

	for (genvar g = 0; g < NUM_FANS; g++)
	begin : g_pwm
		pwm_chan u_pwm
		(
			.clk_sys  (clk_sys),
			.sys_rst  (sys_rst),
			.tick     (pwm_tick),
			.duty     (eff_duty[g]),
			.pin_out  (pwm_out[g]),
			.pin_oe_q (pwm_oe[g])
		);
	end

	// Stopped monitoring compares against fixed defaults, not the registers.
	assign eff_lo = start_q ? lim_lo_q : DEF_LIM_LO;
	assign eff_hi = start_q ? lim_hi_q : DEF_LIM_HI;

	// Measurement register moves only while running.
	always_ff @(posedge clk_sys or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			meas_q <= 8'h00;
		end
		else if (start_q && meas_strobe)
		begin
			meas_q <= meas_sample;
		end
	end

	// Start-up interval after run; readings are flagged invalid until it ends.
	always_ff @(posedge clk_sys or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			settle_q <= '0;
		end
		else if (!start_q)
		begin
			settle_q <= '0;
		end
		else if (!settled)
		begin
			settle_q <= settle_q + 1'b1;
		end
	end

	assign settled    = (settle_q == SETTLE_W'(STARTUP_CYCLES));
	assign meas_valid = start_q && settled;

	// Events only count while running; a sample outside the window after the start-up interval sets bit 0.
	assign violation = meas_strobe && settled && ((meas_sample <= eff_lo) || (meas_sample > eff_hi));
	assign set_vec   = start_q ? {limit_event, violation} : 8'h00;

	// Status clears on read unless its cause is still present; a new event wins.
	always_ff @(posedge clk_sys or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			status_q <= STATUS_RST;
		end
		else if (rd_done && (idx == IDX_STATUS))
		begin
			status_q <= set_vec;
		end
		else
		begin
			status_q <= status_q | set_vec;
		end
	end

	// Read data selection; unmapped indices read zero.
	always_comb
	begin
		rd_mux = 8'h00;
		if (idx == IDX_CTRL)
		begin
			rd_mux = {4'h0, override_q, ready_q, lock_q, start_q};
		end
		else if (idx == IDX_STATUS)
		begin
			rd_mux = status_q;
		end
		else if (idx == IDX_MEAS)
		begin
			rd_mux = meas_q;
		end
		else if (idx == IDX_LIM_LO)
		begin
			rd_mux = lim_lo_q;
		end
		else if (idx == IDX_LIM_HI)
		begin
			rd_mux = lim_hi_q;
		end
		else if (idx == IDX_MANUAL)
		begin
			rd_mux = {5'h00, manual_q};
		end
		else if (idx == IDX_IRQ_EN)
		begin
			rd_mux = {7'h00, irq_en_q};
		end
		else if (in_range(idx, IDX_PARAM0, NUM_PARAMS))
		begin
			rd_mux = param_rdata;
		end
		else if (in_range(idx, IDX_DUTY0, NUM_FANS))
		begin
			rd_mux = rd_duty[idx[1:0]];
		end
		else if (in_range(idx, IDX_TACH0, NUM_TACH_REGS))
		begin
			// Tach readings pass straight through whatever the run bit says.
			rd_mux = idx[0] ? tach_count[idx[2:1]][15:8] : tach_count[idx[2:1]][7:0];
		end
	end

	// Reads wait two cycles so the parameter memory's registered output is ready.
	always_ff @(posedge clk_sys or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			rd_q <= RD_IDLE;
		end
		else
		begin
			case (rd_q)
				RD_IDLE:  rd_q <= avs_read ? RD_FETCH : RD_IDLE;
				RD_FETCH: rd_q <= avs_read ? RD_DONE : RD_IDLE;
				RD_DONE:  rd_q <= RD_IDLE;
				default:  rd_q <= RD_IDLE;
			endcase
		end
	end

	// Read data come from a register loaded on the same edge that waitrequest drops.
	always_ff @(posedge clk_sys or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			avs_readdata <= 32'h00000000;
		end
		else if (avs_read && (rd_q == RD_FETCH))
		begin
			avs_readdata <= {24'h000000, rd_mux};
		end
	end

	assign rd_done         = avs_read && (rd_q == RD_DONE);
	assign avs_waitrequest = avs_read && (rd_q != RD_DONE);
	assign monitor_run     = start_q;
	assign irq_pin_enable  = irq_en_q;

	// Checks on the control behaviour.
	property p_lock_freezes_start;
		@(posedge clk_sys) disable iff (sys_rst)
		lock_q && wr_lo && (idx == IDX_CTRL) |=> $stable(start_q) && lock_q;
	endproperty
	a_lock_freezes_start: assert property (p_lock_freezes_start) else $error("run bit changed while locked");

	property p_lock_sticky;
		@(posedge clk_sys) disable iff (sys_rst)
		lock_q |=> lock_q [*8];
	endproperty
	a_lock_sticky: assert property (p_lock_sticky) else $error("lock bit cleared");

	property p_stopped_full;
		@(posedge clk_sys) disable iff (sys_rst)
		!start_q |-> (eff_duty[0] == DUTY_FULL) && (eff_duty[1] == DUTY_FULL) && (eff_duty[2] == DUTY_FULL);
	endproperty
	a_stopped_full: assert property (p_stopped_full) else $error("stopped PWM not at full duty");

	property p_override_full;
		@(posedge clk_sys) disable iff (sys_rst)
		override_q |-> (eff_duty[0] == DUTY_FULL) && (eff_duty[1] == DUTY_FULL) && (eff_duty[2] == DUTY_FULL);
	endproperty
	a_override_full: assert property (p_override_full) else $error("override did not force full duty");

	property p_no_status_stopped;
		@(posedge clk_sys) disable iff (sys_rst)
		!start_q |=> ((status_q & ~$past(status_q)) == 8'h00);
	endproperty
	a_no_status_stopped: assert property (p_no_status_stopped) else $error("status set while stopped");

	property p_meas_frozen;
		@(posedge clk_sys) disable iff (sys_rst)
		!start_q |=> $stable(meas_q);
	endproperty
	a_meas_frozen: assert property (p_meas_frozen) else $error("measurement moved while stopped");

	property p_limit_locked;
		@(posedge clk_sys) disable iff (sys_rst)
		(start_q || lock_q) && wr_lo && (idx == IDX_LIM_LO) |=> $stable(lim_lo_q);
	endproperty
	a_limit_locked: assert property (p_limit_locked) else $error("limit written while running or locked");

	property p_ready_reads_one;
		@(posedge clk_sys) disable iff (sys_rst)
		rd_done && (idx == IDX_CTRL) |-> avs_readdata[BIT_READY] && (avs_readdata[7:4] == 4'h0);
	endproperty
	a_ready_reads_one: assert property (p_ready_reads_one) else $error("control read lacks ready or shows reserved");

	property p_read_latency;
		@(posedge clk_sys) disable iff (sys_rst)
		$rose(avs_read) |-> avs_waitrequest ##1 avs_waitrequest ##1 !avs_waitrequest;
	endproperty
	a_read_latency: assert property (p_read_latency) else $error("read answer not on third cycle");

	property p_valid_needs_run;
		@(posedge clk_sys) disable iff (sys_rst)
		$rose(start_q) |-> !meas_valid [*8];
	endproperty
	a_valid_needs_run: assert property (p_valid_needs_run) else $error("readings valid too early");

	c_start_set:  cover property (@(posedge clk_sys) disable iff (sys_rst) $rose(start_q));
	c_lock_set:   cover property (@(posedge clk_sys) disable iff (sys_rst) $rose(lock_q));
	c_status_set: cover property (@(posedge clk_sys) disable iff (sys_rst) $rose(status_q[0]));
	c_read_done:  cover property (@(posedge clk_sys) disable iff (sys_rst) rd_done);

endmodule : monitor_run_lock_control

// >>> sensor_front_end.sv
`timescale 1ns/100ps
// Behavioural converter and fan front end that feeds the monitor block.
module sensor_front_end
	import monitor_pkg::*;
(
	input  wire logic                clk_sys,
	input  wire logic                sys_rst,
	input  wire monitor_pkg::byte_t  sample_lvl,
	input  wire logic [6:0]          fault_lvl,
	output logic                     meas_strobe,
	output monitor_pkg::byte_t       meas_sample,
	output logic [6:0]               limit_event,
	output logic [3:0][15:0]         tach_count,
	output logic [2:0][7:0]          auto_duty
);
	logic [3:0] pace_q;

	// A conversion completes every sixteen clocks.
	always_ff @(posedge clk_sys or posedge sys_rst)
	begin
		if (sys_rst)
			pace_q <= 4'h0;
		else
			pace_q <= pace_q + 4'h1;
	end

	// Between strobes the sample line wanders, so a block that latches it off-strobe is caught.
	assign meas_strobe = (pace_q == 4'hF);
	assign meas_sample = meas_strobe ? sample_lvl : {4'hA, pace_q};
	assign limit_event = fault_lvl;
	assign tach_count  = {16'h4433, 16'h3322, 16'h2211, 16'h12AB};
	assign auto_duty   = {8'hFF, 8'h80, 8'h20};
endmodule : sensor_front_end

// >>> monitor_run_lock_control_bench.sv
`timescale 1ns/100ps
module monitor_run_lock_control_bench;
	import monitor_pkg::*;

	localparam int SU = 20;
	logic              clk_sys;
	logic              sys_rst;
	logic [9:0]        avs_address;
	logic              avs_read;
	logic              avs_write;
	logic [31:0]       avs_writedata;
	logic [3:0]        avs_byteenable;
	logic [31:0]       avs_readdata;
	logic              avs_waitrequest;
	logic              meas_strobe;
	byte_t             meas_sample;
	logic [6:0]        limit_event;
	logic [3:0][15:0]  tach_count;
	logic [2:0][7:0]   auto_duty;
	logic [2:0]        pwm_out;
	logic [2:0]        pwm_oe;
	logic              monitor_run;
	logic              meas_valid;
	logic              irq_pin_enable;
	byte_t             sample_lvl;
	logic [6:0]        fault_lvl;
	byte_t             meas_first;
	int                fails;
	int                n_tests;

	monitor_run_lock_control #(.STARTUP_CYCLES(SU)) uut (.clk_sys(clk_sys), .sys_rst(sys_rst),
		.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
		.avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .meas_strobe(meas_strobe), .meas_sample(meas_sample),
		.limit_event(limit_event), .tach_count(tach_count), .auto_duty(auto_duty), .pwm_out(pwm_out),
		.pwm_oe(pwm_oe), .monitor_run(monitor_run), .meas_valid(meas_valid),
		.irq_pin_enable(irq_pin_enable));

	sensor_front_end fe (.clk_sys(clk_sys), .sys_rst(sys_rst), .sample_lvl(sample_lvl),
		.fault_lvl(fault_lvl), .meas_strobe(meas_strobe), .meas_sample(meas_sample),
		.limit_event(limit_event), .tach_count(tach_count), .auto_duty(auto_duty));

	task automatic end_of_test();
		if (fails == 0 && n_tests > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : end_of_test

	task automatic chk_reg(input byte_t got, input byte_t exp);
		n_tests++;
		if (got !== exp)
		begin
			fails++;
			$display("Error at %0t: register read %h, expected %h", $time, got, exp);
		end
	endtask : chk_reg

	task automatic chk_bit(input logic got, input logic exp);
		n_tests++;
		if (got !== exp)
		begin
			fails++;
			$display("Error at %0t: status output %b, expected %b", $time, got, exp);
		end
	endtask : chk_bit

	task automatic chk_cnt(input int got, input int exp);
		n_tests++;
		if (got != exp)
		begin
			fails++;
			$display("Error at %0t: pin driven low %0d clocks, expected %0d", $time, got, exp);
		end
	endtask : chk_cnt

	// One Avalon transfer; entered and left on a rising edge with the bus idle.
	task automatic bus(input logic rd, input byte_t idx, input byte_t wd, output byte_t rv);
		int n;
		n = 0;
		avs_address   <= {idx, 2'b00};
		avs_read      <= rd;
		avs_write     <= ~rd;
		avs_writedata <= {24'h000000, wd};
		// The request stands until a rising edge samples waitrequest low; that edge takes the data.
		do
		begin
			@(posedge clk_sys);
			n++;
		end
		while (avs_waitrequest !== 1'b0 && n < 64);
		if (n >= 64)
		begin
			fails++;
			$display("Error at %0t: bus transfer never completed", $time);
		end
		rv = avs_readdata[7:0];
		avs_read  <= 1'b0;
		avs_write <= 1'b0;
		// One idle edge keeps a following request from reusing this time step.
		@(posedge clk_sys);
	endtask : bus

	task automatic wr(input byte_t idx, input byte_t d);
		byte_t v;
		bus(1'b0, idx, d, v);
	endtask : wr

	task automatic rd_chk(input byte_t idx, input byte_t exp);
		byte_t v;
		bus(1'b1, idx, 8'h00, v);
		chk_reg(v, exp);
	endtask : rd_chk

	// Skip one full PWM period so a new duty has landed, then count low-drive clocks over the next.
	task automatic oe_cnt(input int ch, input int exp);
		int n;
		n = 0;
		repeat (1024) @(posedge clk_sys);
		repeat (1024)
		begin
			@(negedge clk_sys);
			if (pwm_oe[ch] === 1'b1)
				n++;
		end
		@(posedge clk_sys);
		chk_cnt(n, exp);
	endtask : oe_cnt

	// Free-running 10 MHz system clock.
	initial
	begin
		clk_sys = 1'b0;
		forever #50 clk_sys = ~clk_sys;
	end

	// Cuts a hang short well after the expected end of the sequence.
	initial
	begin
		repeat (60000) @(posedge clk_sys);
		fails++;
		end_of_test();
	end

	// Main sequence: stopped, running, stopped again, then a power cycle after which the lock is set.
	initial
	begin
		sys_rst = 1'b1;
		avs_address = 10'h000;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_writedata = 32'h00000000;
		avs_byteenable = 4'h1;
		sample_lvl = 8'h05;
		fault_lvl = 7'h01;
		fails = 0;
		n_tests = 0;
		repeat (8) @(posedge clk_sys);
		sys_rst <= 1'b0;
		@(posedge clk_sys);
		rd_chk(IDX_CTRL, 8'h04);
		oe_cnt(0, 4);
		oe_cnt(2, 4);
		chk_bit(pwm_out[0], 1'b0);
		bus(1'b1, IDX_MEAS, 8'h00, meas_first);
		repeat (64) @(posedge clk_sys);
		rd_chk(IDX_MEAS, meas_first);
		rd_chk(IDX_STATUS, 8'h00);
		rd_chk(IDX_TACH0, 8'hAB);
		rd_chk(IDX_TACH0 + 8'h01, 8'h12);
		wr(IDX_LIM_LO, 8'h10);
		wr(IDX_MANUAL, 8'h01);
		wr(IDX_DUTY0, 8'h40);
		wr(IDX_DUTY0 + 8'h01, 8'h55);
		wr(IDX_PARAM0, 8'h5A);
		rd_chk(IDX_DUTY0, 8'h40);
		rd_chk(IDX_DUTY0 + 8'h01, 8'hFF);
		oe_cnt(0, 4);
		wr(IDX_CTRL, 8'hF1);
		@(negedge clk_sys);
		chk_bit(meas_valid, 1'b0);
		chk_bit(monitor_run, 1'b1);
		@(posedge clk_sys);
		rd_chk(IDX_CTRL, 8'h05);
		repeat (SU + 4) @(posedge clk_sys);
		@(negedge clk_sys);
		chk_bit(meas_valid, 1'b1);
		repeat (32) @(posedge clk_sys);
		rd_chk(IDX_MEAS, 8'h05);
		rd_chk(IDX_STATUS, 8'h03);
		rd_chk(IDX_PARAM0, 8'h5A);
		wr(IDX_LIM_LO, 8'h22);
		rd_chk(IDX_LIM_LO, 8'h10);
		wr(IDX_MANUAL, 8'h07);
		rd_chk(IDX_MANUAL, 8'h01);
		wr(IDX_DUTY0 + 8'h01, 8'h11);
		rd_chk(IDX_DUTY0 + 8'h01, 8'h80);
		oe_cnt(0, 768);
		oe_cnt(1, 512);
		wr(IDX_DUTY0, 8'h80);
		rd_chk(IDX_DUTY0, 8'h80);
		oe_cnt(0, 512);
		wr(IDX_IRQ_EN, 8'h01);
		rd_chk(IDX_IRQ_EN, 8'h01);
		chk_bit(irq_pin_enable, 1'b1);
		wr(IDX_CTRL, 8'h09);
		oe_cnt(0, 4);
		wr(IDX_CTRL, 8'h00);
		@(negedge clk_sys);
		chk_bit(monitor_run, 1'b0);
		@(posedge clk_sys);
		rd_chk(IDX_LIM_LO, 8'h10);
		rd_chk(IDX_DUTY0 + 8'h01, 8'hFF);
		rd_chk(8'h3E, 8'h00);
		wr(IDX_CTRL, 8'hF0);
		rd_chk(IDX_CTRL, 8'h04);
		sys_rst <= 1'b1;
		repeat (8) @(posedge clk_sys);
		sys_rst <= 1'b0;
		@(posedge clk_sys);
		wr(IDX_CTRL, 8'h02);
		wr(IDX_LIM_LO, 8'h33);
		rd_chk(IDX_LIM_LO, LIM_LO_RST);
		wr(IDX_CTRL, 8'h01);
		@(negedge clk_sys);
		chk_bit(monitor_run, 1'b0);
		@(posedge clk_sys);
		wr(IDX_CTRL, 8'h08);
		rd_chk(IDX_CTRL, 8'h0E);
		oe_cnt(1, 4);
		end_of_test();
	end
endmodule : monitor_run_lock_control_bench
